// ---- rtl/srb_ctrl.sv ----
// Receive self-test checker, elasticity buffer, status mode and power latches.
// Assumes decoded characters arrive with a valid strobe and reference ticks are
// synchronous strobes on the same clock.
//
// Function
// - Self-test latch open: enable bus bit0 low enables rx checker, bit1 low tx generator.
// - Self-test latch enable falling holds both enable bus bits until reopened.
// - Device reset sets every self-test latch bit high, disabling self-test.
// - Enabled checker runs a 511-state LFSR covering data, special and violation codes.
// - Synchronised checker compares each character and reports on the status bits.
// - First recognised enable presets LFSR to start code D0.0, once per loop.
// - Expected violations and disparity errors inside the loop are not errors.
// - Loop completion shows 010b or 100b for one character, also in bypass.
// - Self-test status replaces normal status regardless of decoder mode.
// - Invalid exceeding valid by 16 aborts and returns LFSR to D0.0.
// - Elasticity buffer holds 10 entries of 12 bits.
// - Buffer written on recovered side, read on reference ticks when selected.
// - Select low: reference timing and buffer active; mid or open: recovered timing.
// - Decoder bypass also bypasses the buffer; configuring party sets select mid.
// - Buffer inserts K28.5 or deletes framing characters only with framing held.
// - Status mode low gives scheme A, high scheme B; ignored in bypass.
// - Rx latch open: enable bus bit0 powers receive channel; falling edge holds it.
// - Tx latch open: each bus bit enables its driver; both off powers down tx.
// - Device reset clears transmit and receive enable latches.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
module srb_ctrl (
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // Latch control pins
    input wire logic [1:0] ENABLE_SELECT_BUS_IN,
    input wire logic SELF_TEST_LATCH_ENABLE_IN,
    input wire logic RX_POWER_LATCH_ENABLE_IN,
    input wire logic TX_POWER_LATCH_ENABLE_IN,
    // Mode pins, three-level encoded
    input wire logic [1:0] RX_CLOCK_SELECT_IN,
    input wire logic [1:0] DECODER_MODE_SELECT_IN,
    input wire logic [1:0] RX_STATUS_MODE_SELECT_IN,
    // Receive character stream
    input wire srb_pkg::srb_char_t RX_CHAR_IN,
    input wire logic RX_CHAR_VALID_IN,
    input wire logic REF_TICK_IN,
    // Receive output register
    output srb_pkg::srb_entry_t RX_OUT,
    output logic RX_OUT_VALID_OUT,
    output logic RX_FROM_REFERENCE_OUT,
    output logic BUFFER_BYPASS_OUT,
    // Power and self-test enables
    output logic RX_POWER_EN_OUT,
    output logic [1:0] TX_DRIVER_EN_OUT,
    output logic TX_CHANNEL_POWER_OUT,
    output logic TX_SELF_TEST_EN_OUT,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import srb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // XNOR feedback lets the all-zero start code live inside the sequence
    function automatic logic [8:0] lfsr_next(input logic [8:0] s);
        lfsr_next = {s[7:0], ~(s[8] ^ s[4])};
    endfunction

    function automatic logic exp_violation(input logic [8:0] s);
        exp_violation = s[8] & s[7] & s[6] & s[5];
    endfunction

    // A character matches the expected LFSR character
    function automatic logic char_match(input logic [8:0] s, input srb_char_t c);
        if (exp_violation(s)) begin
            char_match = c.err;
        end else begin
            char_match = !c.err && c.data == s[7:0] && c.kchar == (s[8] & s[7]);
        end
    endfunction

    function automatic logic odd_parity(input logic [7:0] d);
        odd_parity = ~(^d);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Latches: transparent while the enable is high, hold after it falls

    logic [1:0] st_latch_r;
    logic [1:0] rx_latch_r;
    logic [1:0] tx_latch_r;
    logic [1:0] st_eff;
    logic [1:0] rx_eff;
    logic [1:0] tx_eff;

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            st_latch_r <= SELF_TEST_LATCH_RST;
        end else if (SELF_TEST_LATCH_ENABLE_IN) begin
            st_latch_r <= ENABLE_SELECT_BUS_IN;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            rx_latch_r <= POWER_LATCH_RST;
            tx_latch_r <= POWER_LATCH_RST;
        end else begin
            if (RX_POWER_LATCH_ENABLE_IN) begin
                rx_latch_r <= ENABLE_SELECT_BUS_IN;
            end
            if (TX_POWER_LATCH_ENABLE_IN) begin
                tx_latch_r <= ENABLE_SELECT_BUS_IN;
            end
        end
    end

    // Open latch passes the bus straight through; reset overrides the pins
    assign st_eff = !RST_N_IN ? SELF_TEST_LATCH_RST :
        (SELF_TEST_LATCH_ENABLE_IN ? ENABLE_SELECT_BUS_IN : st_latch_r);
    assign rx_eff = !RST_N_IN ? POWER_LATCH_RST :
        (RX_POWER_LATCH_ENABLE_IN ? ENABLE_SELECT_BUS_IN : rx_latch_r);
    assign tx_eff = !RST_N_IN ? POWER_LATCH_RST :
        (TX_POWER_LATCH_ENABLE_IN ? ENABLE_SELECT_BUS_IN : tx_latch_r);

    logic rx_test_en;
    assign rx_test_en = ~st_eff[0];
    assign TX_SELF_TEST_EN_OUT = ~st_eff[1];
    assign RX_POWER_EN_OUT = rx_eff[0];
    assign TX_DRIVER_EN_OUT = tx_eff;
    assign TX_CHANNEL_POWER_OUT = |tx_eff;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic bypass;
    logic ref_mode;
    logic scheme_b;
    assign bypass = DECODER_MODE_SELECT_IN == LVL_LOW;
    assign ref_mode = RX_CLOCK_SELECT_IN == LVL_LOW && !bypass;
    assign scheme_b = !bypass && RX_STATUS_MODE_SELECT_IN == LVL_HIGH;
    assign RX_FROM_REFERENCE_OUT = ref_mode;
    assign BUFFER_BYPASS_OUT = !ref_mode;

    ////////////////////////////////////////////////////////////////////////////
    // APB control strobes

    logic apb_wr;
    logic sw_clear;
    logic sw_restart;
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign sw_clear = apb_wr && PADDR == OFS_CTRL && PWDATA[CTRL_CLR_BIT];
    assign sw_restart = apb_wr && PADDR == OFS_CTRL && PWDATA[CTRL_RESTART_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Self-test checker

    srb_chk_state_t chk_state_r;
    logic [8:0] lfsr_r;
    logic [4:0] diff_r;
    logic [2:0] chk_status;
    logic chk_mismatch;
    logic chk_loop;
    logic loop_code_sel;

    assign loop_code_sel = scheme_b;
    assign chk_mismatch = chk_state_r == CHK_RUN && RX_CHAR_VALID_IN
        && !char_match(lfsr_r, RX_CHAR_IN);
    assign chk_loop = chk_state_r == CHK_RUN && RX_CHAR_VALID_IN
        && lfsr_r == LFSR_START && char_match(lfsr_r, RX_CHAR_IN);

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            chk_state_r <= CHK_IDLE;
            lfsr_r <= LFSR_START;
            diff_r <= 5'h00;
        end else if (!rx_test_en) begin
            chk_state_r <= CHK_IDLE;
            lfsr_r <= LFSR_START;
            diff_r <= 5'h00;
        end else begin
            unique case (chk_state_r)
                CHK_IDLE: begin
                    chk_state_r <= CHK_SEARCH;
                    lfsr_r <= LFSR_START;
                    diff_r <= 5'h00;
                end
                CHK_SEARCH: begin
                    if (RX_CHAR_VALID_IN && char_match(LFSR_START, RX_CHAR_IN)) begin
                        chk_state_r <= CHK_RUN;
                        lfsr_r <= lfsr_next(LFSR_START);
                    end
                end
                CHK_RUN: begin
                    if (sw_restart) begin
                        chk_state_r <= CHK_SEARCH;
                        lfsr_r <= LFSR_START;
                        diff_r <= 5'h00;
                    end else if (RX_CHAR_VALID_IN) begin
                        if (chk_mismatch && diff_r == ABORT_MARGIN - 5'h01) begin
                            chk_state_r <= CHK_SEARCH;
                            lfsr_r <= LFSR_START;
                            diff_r <= 5'h00;
                        end else begin
                            lfsr_r <= lfsr_next(lfsr_r);
                            if (chk_mismatch) begin
                                diff_r <= diff_r + 5'h01;
                            end else if (diff_r != 5'h00) begin
                                diff_r <= diff_r - 5'h01;
                            end
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        if (chk_state_r != CHK_RUN) begin
            chk_status = ST_SEARCH;
        end else if (chk_mismatch) begin
            chk_status = ST_MISMATCH;
        end else if (chk_loop) begin
            chk_status = loop_code_sel ? ST_LOOP_B : ST_LOOP_A;
        end else begin
            chk_status = RX_CHAR_IN.kchar ? ST_SPECIAL : ST_DATA;
        end
    end

    // Write-side entry: self-test status wins over decoder status
    srb_entry_t wr_entry;
    always_comb begin
        wr_entry.data = RX_CHAR_IN.data;
        wr_entry.status = rx_test_en ? chk_status : RX_CHAR_IN.status;
        wr_entry.parity = odd_parity(RX_CHAR_IN.data);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Elasticity buffer

    srb_entry_t eb_mem_r [EB_DEPTH];
    logic [EB_DEPTH-1:0] eb_frame_r;
    logic [3:0] eb_wp_r;
    logic [3:0] eb_rp_r;
    logic [3:0] eb_cnt_r;
    logic eb_has_frame;
    logic eb_push;
    logic eb_pop;
    logic eb_insert;

    // Slips happen only on framing characters; a push into a full buffer still overwrites an unread entry
    assign eb_has_frame = |eb_frame_r;
    assign eb_push = ref_mode && RX_CHAR_VALID_IN && !(RX_CHAR_IN.framing
        && eb_cnt_r >= EB_HIGH_MARK && eb_has_frame);
    assign eb_insert = ref_mode && REF_TICK_IN && eb_cnt_r <= EB_LOW_MARK
        && eb_has_frame;
    assign eb_pop = ref_mode && REF_TICK_IN && !eb_insert && eb_cnt_r != 4'h0;

    function automatic logic [3:0] eb_inc(input logic [3:0] p);
        eb_inc = p == EB_LAST ? 4'h0 : p + 4'h1;
    endfunction

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            for (int i = 0; i < EB_DEPTH; i++) begin
                eb_mem_r[i] <= '0;
            end
            eb_frame_r <= '0;
            eb_wp_r <= EB_CENTRE;
            eb_rp_r <= 4'h0;
            eb_cnt_r <= EB_CENTRE;
        end else begin
            if (eb_push) begin
                eb_mem_r[eb_wp_r] <= wr_entry;
                eb_frame_r[eb_wp_r] <= RX_CHAR_IN.framing;
                eb_wp_r <= eb_inc(eb_wp_r);
            end
            if (eb_pop) begin
                eb_rp_r <= eb_inc(eb_rp_r);
                if (!(eb_push && eb_wp_r == eb_rp_r)) begin
                    eb_frame_r[eb_rp_r] <= 1'b0;
                end
            end
            if (eb_push && !eb_pop && eb_cnt_r != EB_DEPTH[3:0]) begin
                eb_cnt_r <= eb_cnt_r + 4'h1;
            end else if (eb_pop && !eb_push) begin
                eb_cnt_r <= eb_cnt_r - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output register

    srb_entry_t k28_entry;
    assign k28_entry = '{data: K28_5_DATA, status: ST_SPECIAL,
        parity: odd_parity(K28_5_DATA)};

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            RX_OUT <= '0;
            RX_OUT_VALID_OUT <= 1'b0;
        end else if (ref_mode) begin
            RX_OUT_VALID_OUT <= eb_pop || eb_insert;
            if (eb_insert) begin
                RX_OUT <= k28_entry;
            end else if (eb_pop) begin
                RX_OUT <= eb_mem_r[eb_rp_r];
            end
        end else begin
            RX_OUT_VALID_OUT <= RX_CHAR_VALID_IN;
            if (RX_CHAR_VALID_IN) begin
                RX_OUT <= wr_entry;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counters; an event in the clearing cycle still counts

    logic [15:0] mis_cnt_r;
    logic [15:0] loop_cnt_r;

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            mis_cnt_r <= 16'h0000;
            loop_cnt_r <= 16'h0000;
        end else begin
            if (sw_clear) begin
                mis_cnt_r <= {15'h0000, chk_mismatch};
                loop_cnt_r <= {15'h0000, chk_loop};
            end else begin
                if (chk_mismatch && mis_cnt_r != 16'hffff) begin
                    mis_cnt_r <= mis_cnt_r + 16'h0001;
                end
                if (chk_loop && loop_cnt_r != 16'hffff) begin
                    loop_cnt_r <= loop_cnt_r + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read path, zero wait states

    logic addr_ok;
    assign addr_ok = PADDR == OFS_CTRL || PADDR == OFS_STATUS
        || PADDR == OFS_MISMATCH || PADDR == OFS_LOOPS;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;

    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE) begin
            unique case (PADDR)
                OFS_STATUS: PRDATA = {16'h0000, eb_cnt_r, 2'b00, chk_state_r,
                    2'b00, st_eff, rx_eff, tx_eff};
                OFS_MISMATCH: PRDATA = {16'h0000, mis_cnt_r};
                OFS_LOOPS: PRDATA = {16'h0000, loop_cnt_r};
                default: PRDATA = 32'h0000_0000;
            endcase
        end
    end

endmodule

// ---- rtl/srb_pkg.sv ----
// Shared constants and carrier types for the receive self-test, elasticity and power block.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package srb_pkg;

    // Three-level pin encoding: open reads as mid
    localparam logic [1:0] LVL_LOW = 2'b00;
    localparam logic [1:0] LVL_MID = 2'b01;
    localparam logic [1:0] LVL_HIGH = 2'b10;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MISMATCH = 8'h08;
    localparam logic [7:0] OFS_LOOPS = 8'h0c;

    // Control bit positions
    localparam int CTRL_CLR_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;

    // Latch values after reset
    localparam logic [1:0] SELF_TEST_LATCH_RST = 2'b11;
    localparam logic [1:0] POWER_LATCH_RST = 2'b00;

    // Self-test sequence
    localparam int LFSR_W = 9;
    localparam logic [8:0] LFSR_START = 9'h000;
    localparam logic [4:0] ABORT_MARGIN = 5'h10;

    // Status encodings
    localparam logic [2:0] ST_DATA = 3'h0;
    localparam logic [2:0] ST_SPECIAL = 3'h1;
    localparam logic [2:0] ST_LOOP_A = 3'h2;
    localparam logic [2:0] ST_LOOP_B = 3'h4;
    localparam logic [2:0] ST_MISMATCH = 3'h6;
    localparam logic [2:0] ST_SEARCH = 3'h7;

    // Elasticity buffer
    localparam int EB_DEPTH = 10;
    localparam logic [3:0] EB_LAST = 4'h9;
    localparam logic [3:0] EB_CENTRE = 4'h5;
    localparam logic [3:0] EB_LOW_MARK = 4'h2;
    localparam logic [3:0] EB_HIGH_MARK = 4'h8;
    localparam logic [7:0] K28_5_DATA = 8'hbc;

    // Decoded character arriving from the decoder on the recovered side
    typedef struct packed {
        logic [7:0] data;
        logic kchar;
        logic err;
        logic framing;
        logic [2:0] status;
    } srb_char_t;

    // One 12-bit buffer and output entry
    typedef struct packed {
        logic [7:0] data;
        logic [2:0] status;
        logic parity;
    } srb_entry_t;

    typedef enum logic [1:0] {
        CHK_IDLE,
        CHK_SEARCH,
        CHK_RUN
    } srb_chk_state_t;

endpackage

// ---- dv/srb_props.sv ----
// Checker for the receive control block: latches, timing source and stream timing.
// Assumes it is bound to srb_ctrl and sees only its ports on the one clock.
`timescale 1ns/10ps
module srb_props import srb_pkg::*; (
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RST_N_IN,
    // Control pins
    input wire logic [1:0] ENABLE_SELECT_BUS_IN,
    input wire logic SELF_TEST_LATCH_ENABLE_IN,
    input wire logic RX_POWER_LATCH_ENABLE_IN,
    input wire logic TX_POWER_LATCH_ENABLE_IN,
    input wire logic [1:0] RX_CLOCK_SELECT_IN,
    input wire logic [1:0] DECODER_MODE_SELECT_IN,
    input wire logic RX_CHAR_VALID_IN,
    input wire logic REF_TICK_IN,
    // Observed outputs
    input wire logic RX_OUT_VALID_OUT,
    input wire logic RX_FROM_REFERENCE_OUT,
    input wire logic BUFFER_BYPASS_OUT,
    input wire logic RX_POWER_EN_OUT,
    input wire logic [1:0] TX_DRIVER_EN_OUT,
    input wire logic TX_CHANNEL_POWER_OUT,
    input wire logic TX_SELF_TEST_EN_OUT
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    ////////////////////////////////////////
    a_st_follow: assert property (SELF_TEST_LATCH_ENABLE_IN |->
        TX_SELF_TEST_EN_OUT == !ENABLE_SELECT_BUS_IN[1]) else $error("self-test not following bus");
    a_st_hold: assert property (!SELF_TEST_LATCH_ENABLE_IN |->
        $stable(TX_SELF_TEST_EN_OUT)) else $error("self-test latch not held");
    a_reset_latches: assert property (disable iff (1'b0) !RST_N_IN |->
        !TX_SELF_TEST_EN_OUT && !RX_POWER_EN_OUT && TX_DRIVER_EN_OUT == 2'h0)
        else $error("latches not at reset values");
    a_rx_follow: assert property (RX_POWER_LATCH_ENABLE_IN |->
        RX_POWER_EN_OUT == ENABLE_SELECT_BUS_IN[0]) else $error("rx power not following bus");
    a_rx_hold: assert property (!RX_POWER_LATCH_ENABLE_IN |->
        $stable(RX_POWER_EN_OUT)) else $error("rx power latch not held");
    a_tx_follow: assert property (TX_POWER_LATCH_ENABLE_IN |->
        TX_DRIVER_EN_OUT == ENABLE_SELECT_BUS_IN) else $error("tx drivers not following bus");
    a_tx_power: assert property (TX_CHANNEL_POWER_OUT ==
        (|TX_DRIVER_EN_OUT)) else $error("tx channel power wrong");
    a_ref_timing: assert property (RX_FROM_REFERENCE_OUT ==
        (RX_CLOCK_SELECT_IN == LVL_LOW && DECODER_MODE_SELECT_IN != LVL_LOW))
        else $error("timing source wrong");
    a_dec_bypass: assert property (DECODER_MODE_SELECT_IN == LVL_LOW |->
        BUFFER_BYPASS_OUT) else $error("buffer not bypassed");
    a_rec_out: assert property (BUFFER_BYPASS_OUT && RX_CHAR_VALID_IN |=>
        RX_OUT_VALID_OUT) else $error("recovered character not output");
    a_ref_hold: assert property (RX_FROM_REFERENCE_OUT && !REF_TICK_IN |=>
        !RX_OUT_VALID_OUT) else $error("output without reference tick");
endmodule

bind srb_ctrl srb_props u_props (.CLOCK_IN, .RST_N_IN, .ENABLE_SELECT_BUS_IN,
    .SELF_TEST_LATCH_ENABLE_IN, .RX_POWER_LATCH_ENABLE_IN, .TX_POWER_LATCH_ENABLE_IN,
    .RX_CLOCK_SELECT_IN, .DECODER_MODE_SELECT_IN, .RX_CHAR_VALID_IN, .REF_TICK_IN,
    .RX_OUT_VALID_OUT, .RX_FROM_REFERENCE_OUT, .BUFFER_BYPASS_OUT, .RX_POWER_EN_OUT,
    .TX_DRIVER_EN_OUT, .TX_CHANNEL_POWER_OUT, .TX_SELF_TEST_EN_OUT);

// ---- dv/srb_remote_tx.sv ----
// Remote transmitter model: word sync and self-test characters toward the receiver.
// Assumes one-cycle start requests from the bench on the shared clock.
`timescale 1ns/10ps
module srb_remote_tx import srb_pkg::*; (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Request
    input wire logic start_in,
    input wire logic [10:0] count_in,
    input wire logic ref_mode_in,
    input wire logic bad_in,
    input wire logic slow_in,
    // Character stream
    output srb_pkg::srb_char_t char_out,
    output logic valid_out,
    output logic busy_out
);
    logic [8:0] lfsr_r;
    logic [10:0] left_r;
    logic [4:0] sync_r;
    logic [1:0] gap_r;
    logic go;
    logic k;
    assign busy_out = (left_r != 11'h0) || (sync_r != 5'h0);
    assign go = busy_out && (gap_r == 2'h0);
    assign k = (lfsr_r[8] & lfsr_r[7]) | bad_in;
    ////////////////////////////////////////
    // Slow pacing leaves two idle cycles per character
    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            gap_r <= 2'h0;
        else if (go && slow_in)
            gap_r <= 2'h2;
        else if (gap_r != 2'h0)
            gap_r <= gap_r - 2'h1;
    end
    always_ff @(posedge clk_in) begin
        valid_out <= rst_n_in && !start_in && go;
        if (!rst_n_in) begin
            lfsr_r <= LFSR_START;
            left_r <= 11'h0;
            sync_r <= 5'h0;
            char_out <= '0;
        end else if (start_in) begin
            left_r <= count_in;
            sync_r <= ref_mode_in ? 5'h10 : 5'h0;
        end else if (!go) begin
            // Idle line inverts every cycle, so the last character returns on each second idle cycle
            char_out <= ~char_out;
        end else if (sync_r != 5'h0) begin
            char_out <= {K28_5_DATA, 1'b1, 1'b0, 1'b1, ST_SPECIAL};
            sync_r <= sync_r - 5'h1;
        end else begin
            // Bad characters are special codes, so never mistaken for the start code
            char_out.data <= lfsr_r[7:0] ^ (bad_in ? 8'h5a : 8'h00);
            char_out.kchar <= k;
            char_out.err <= lfsr_r[8:5] == 4'hf;
            char_out.framing <= 1'b0;
            char_out.status <= {2'h0, k};
            lfsr_r <= {lfsr_r[7:0], ~(lfsr_r[8] ^ lfsr_r[4])};
            left_r <= left_r - 11'h1;
        end
    end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench: latches, buffer in reference mode, self-test loop over APB.
// Assumes srb_ctrl, its checker bind and the remote transmitter model.
`timescale 1ns/10ps
module tb;
    import srb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] bus = 2'h3;
    logic ste = 1'b0;
    logic rle = 1'b0;
    logic tle = 1'b0;
    logic [1:0] cksel = LVL_MID;
    logic [1:0] dec = LVL_MID;
    logic [1:0] rmode = LVL_LOW;
    logic tick = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic start = 1'b0;
    logic [10:0] cnt = 11'h0;
    logic refm = 1'b0;
    logic bad = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, serr, mvalid, mbusy, rx_v, from_ref, bypass, rx_pwr, tx_pwr, tx_st;
    logic [1:0] tx_drv;
    srb_char_t mchar;
    srb_entry_t rx_out, last_out;
    int err_total = 0, total_checks = 0, outs = 0, n_la = 0, n_lb = 0, n_mis = 0, cyc = 0, o0;
    srb_ctrl dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ENABLE_SELECT_BUS_IN(bus),
        .SELF_TEST_LATCH_ENABLE_IN(ste), .RX_POWER_LATCH_ENABLE_IN(rle),
        .TX_POWER_LATCH_ENABLE_IN(tle), .RX_CLOCK_SELECT_IN(cksel),
        .DECODER_MODE_SELECT_IN(dec), .RX_STATUS_MODE_SELECT_IN(rmode), .RX_CHAR_IN(mchar),
        .RX_CHAR_VALID_IN(mvalid), .REF_TICK_IN(tick), .RX_OUT(rx_out), .RX_OUT_VALID_OUT(rx_v),
        .RX_FROM_REFERENCE_OUT(from_ref), .BUFFER_BYPASS_OUT(bypass), .RX_POWER_EN_OUT(rx_pwr),
        .TX_DRIVER_EN_OUT(tx_drv), .TX_CHANNEL_POWER_OUT(tx_pwr), .TX_SELF_TEST_EN_OUT(tx_st),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    srb_remote_tx remote (.clk_in(clk), .rst_n_in(rst_n), .start_in(start), .count_in(cnt),
        .ref_mode_in(refm), .bad_in(bad), .slow_in(slow), .char_out(mchar), .valid_out(mvalid),
        .busy_out(mbusy));
    ////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rx_v === 1'b1) begin
            outs++;
            last_out = rx_out;
            n_la += (rx_out.status === ST_LOOP_A);
            n_lb += (rx_out.status === ST_LOOP_B);
            n_mis += (rx_out.status === ST_MISMATCH);
        end
        cyc++;
        if (cyc == 12000) begin
            err_total++;
            $display("ERROR run expected finish seen timeout");
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready is sampled with select and enable; request held until then
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic send(input logic [10:0] n, input logic b);
        @(posedge clk);
        cnt <= n;
        bad <= b;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        do @(posedge clk); while (mbusy === 1'b1);
        repeat (4) @(posedge clk);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("latches", rdat[5:0], 6'h30);
        chk("buffer count", rdat[15:12], EB_CENTRE);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped error", serr, 1'b1);
        chk("unmapped data", rdat, 32'h0);
        $display("test reset done");
        cksel <= LVL_LOW;
        refm <= 1'b1;
        send(11'h0, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("full count", rdat[15:12], 4'h8);
        o0 = outs;
        ticks(7);
        chk("tick outputs", outs - o0, 7);
        chk("inserted data", last_out.data, K28_5_DATA);
        chk("inserted status", last_out.status, ST_SPECIAL);
        chk("inserted parity", last_out.parity, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("low count", rdat[15:12], 4'h2);
        cksel <= LVL_MID;
        refm <= 1'b0;
        $display("test buffer done");
        bus <= 2'h1;
        rle <= 1'b1;
        tle <= 1'b1;
        @(posedge clk);
        rle <= 1'b0;
        tle <= 1'b0;
        @(posedge clk);
        bus <= 2'h2;
        @(posedge clk);
        @(posedge clk);
        chk("rx power", rx_pwr, 1'b1);
        chk("tx drivers", tx_drv, 2'h1);
        tle <= 1'b1;
        bus <= 2'h0;
        @(posedge clk);
        @(posedge clk);
        chk("tx power off", tx_pwr, 1'b0);
        tle <= 1'b0;
        ste <= 1'b1;
        @(posedge clk);
        ste <= 1'b0;
        @(posedge clk);
        bus <= 2'h3;
        @(posedge clk);
        @(posedge clk);
        chk("tx self-test", tx_st, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("self-test latch", rdat[5:4], 2'h0);
        $display("test latches done");
        send(11'd1023, 1'b0);
        chk("loop A codes", n_la, 2);
        chk("no mismatch", n_mis, 0);
        apb(1'b0, OFS_LOOPS, 32'h0);
        chk("loop count", rdat, 32'h2);
        rmode <= LVL_HIGH;
        slow <= 1'b1;
        send(11'd511, 1'b0);
        chk("loop B codes", n_lb, 1);
        dec <= LVL_LOW;
        send(11'd511, 1'b0);
        chk("bypass loop", n_la, 3);
        dec <= LVL_MID;
        send(11'd1, 1'b1);
        chk("mismatch code", n_mis, 1);
        apb(1'b0, OFS_MISMATCH, 32'h0);
        chk("mismatch count", rdat, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1 << CTRL_CLR_BIT);
        apb(1'b0, OFS_MISMATCH, 32'h0);
        chk("cleared count", rdat, 32'h0);
        send(11'd20, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("aborted search", rdat[9:8], 2'h1);
        $display("test self-test done");
        end_sim();
    end
endmodule
